// [rtl/sfsr_pkg.sv]
// package: constants and types of the serial frame status responder
package sfsr_pkg;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int SFSR_BYTE_W    = 8;
  localparam int SFSR_ADDR_W    = 5;
  localparam int SFSR_MIN_BITS  = 16;

  // ----------------------------------------------------------------
  // address byte fields
  // ----------------------------------------------------------------
  localparam int SFSR_AB_ONE_POS  = 0;  // must be 1
  localparam int SFSR_AB_LAST_POS = 1;  // last address marker
  localparam int SFSR_AB_ADDR_LO  = 2;
  localparam int SFSR_AB_ADDR_HI  = 6;
  localparam int SFSR_AB_WR_POS   = 7;  // operation select bit

  // ----------------------------------------------------------------
  // status byte fields and reset values
  // ----------------------------------------------------------------
  localparam int SFSR_ST_TWARN_POS = 0;
  localparam int SFSR_ST_TSHUT_POS = 1;
  localparam int SFSR_ST_RABS_POS  = 2;
  localparam int SFSR_ST_SHIGH_POS = 3;
  localparam int SFSR_ST_SLOW_POS  = 4;
  localparam int SFSR_ST_LOAD_POS  = 5;
  localparam int SFSR_ST_PERR_POS  = 7;

  localparam logic       SFSR_PERR_RST = 1'h0;
  localparam logic       SFSR_RABS_RST = 1'h0;
  localparam logic [7:0] SFSR_SNAP_RST = 8'h00;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0]  SFSR_GSTAT_ADDR = 5'h0c;
  localparam logic [31:0] SFSR_VALID_MAP  = 32'h7fff_ffff;

  // core-side frame tracker
  typedef enum logic [2:0] {
    SFSR_S_IDLE  = 3'h1,
    SFSR_S_FRAME = 3'h2,
    SFSR_S_EVAL  = 3'h4
  } sfsr_state_t;

endpackage

// [rtl/sfsr_responder.sv]
// module: serial frame status responder (slave framing, fault summary, protocol checks)
`timescale 1ns/1ps
`default_nettype none
// How it works
// - before the first clock edge, output carries fault summary OR serial input
// - fault summary is set by any fault and after power-on reset
// - a frame without clocks shows the fault summary and is valid unless the clock is high at a chip select edge
// - first eight clocks shift out the global status byte
// - fault summary ORs all status failures and the inverted reset-absent bit
// - load fault bit is the OR of open-load and overcurrent faults
// - reset-absent bit is 0 after reset so the summary reads 1
// - a protocol error sets status bit 7 seen in the next frame
// - nonzero clock count not a multiple of 8 or below 16 is an error
// - command to an unused register address is an error
// - address byte with bit 0 not set is an error
// - missing last-address marker in the final address byte is an error
// - serial clock high at either chip select edge is an error
// - address byte holds operation bit and register address in bits 6..2
// - data slot carries the addressed register contents in the same frame
// - chain returns status bytes last device first after the combined summary
// - chain returns response bytes last device first after the status bytes
// - input sampled on falling clock, output changes on rising clock
// - frame interpreted after chip select rises, output then released
// - operation bit is bit 7: 0 read, 1 write or clear
// - protocol error bit is never cleared except by a master command or by reset
module sfsr_responder
  import sfsr_pkg::*;
#(
  parameter int          LOAD_N    = 8,
  parameter int          CNT_W     = 10,
  parameter logic [31:0] VALID_MAP = SFSR_VALID_MAP
) (
  input  wire logic                   CLOCK,
  input  wire logic                   RST_B,
  input  wire logic                   SCLK,
  input  wire logic                   CSN_B,
  input  wire logic                   SDI,
  output var  logic                   SDO_O,
  output var  logic                   SDO_OE,
  input  wire logic [LOAD_N-1:0]      OPEN_LOAD_FAULT,
  input  wire logic [LOAD_N-1:0]      OVERCURRENT_FAULT,
  input  wire logic                   SUPPLY_LOW_BIT,
  input  wire logic                   SUPPLY_HIGH_BIT,
  input  wire logic                   THERMAL_SHUTDOWN_BIT,
  input  wire logic                   THERMAL_WARNING_BIT,
  output var  logic                   FAULT_SUMMARY_FLAG,
  output var  logic                   RESET_ABSENT_BIT,
  output var  logic                   PROTO_ERR_BIT,
  output var  logic [SFSR_ADDR_W-1:0] RD_ADDR,
  input  wire logic [SFSR_BYTE_W-1:0] RD_DATA,
  output var  logic                   CMD_STB,
  output var  logic                   CMD_WRITE,
  output var  logic [SFSR_ADDR_W-1:0] CMD_ADDR,
  output var  logic [SFSR_BYTE_W-1:0] CMD_DATA
);

  localparam int SLOT_W = CNT_W - 3;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (CNT_W < 5 || LOAD_N < 1) begin : g_bad_param
    $error("sfsr_responder: CNT_W must be at least 5 and LOAD_N at least 1");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic count_bad(input logic [CNT_W-1:0] cnt);
    count_bad = (cnt != '0) &&
                ((cnt[2:0] != 3'h0) || (cnt < CNT_W'(SFSR_MIN_BITS)));
  endfunction

  function automatic logic addr_unused(input logic [SFSR_BYTE_W-1:0] abyte);
    addr_unused = !VALID_MAP[abyte[SFSR_AB_ADDR_HI:SFSR_AB_ADDR_LO]];
  endfunction

  // link side (serial clock domain)
  logic [CNT_W-1:0]       rx_cnt_reg;
  logic [CNT_W-1:0]       tx_cnt_reg;
  logic [SFSR_BYTE_W-1:0] rx_shift_reg;
  logic [SFSR_BYTE_W-1:0] rx_byte;
  logic [SFSR_BYTE_W-1:0] fwd_byte_reg;
  logic [SFSR_BYTE_W-1:0] own_addr_reg;
  logic [SFSR_BYTE_W-1:0] data_reg;
  logic [SFSR_BYTE_W-1:0] tx_shift_reg;
  logic [SFSR_BYTE_W-1:0] tx_load;
  logic [SLOT_W-1:0]      resp_slot_reg;
  logic [SLOT_W-1:0]      rx_slot;
  logic [SLOT_W-1:0]      tx_slot;
  logic                   byte_done;
  logic                   got_last_reg;
  logic                   one_bad_reg;
  logic                   tx_bit_reg;
  // core side (CLOCK domain)
  sfsr_state_t            state_reg;
  logic [CNT_W-1:0]       edge_cnt_reg;
  logic [SFSR_BYTE_W-1:0] status_now;
  logic [SFSR_BYTE_W-1:0] status_snap_reg;
  logic [SFSR_BYTE_W-1:0] rsp_reg;
  logic                   csn_s1, csn_s2, csn_d;
  logic                   sclk_s1, sclk_s2, sclk_d;
  logic                   sdi_s1, sdi_s2;
  logic                   last_s1, last_s2, last_d;
  logic                   txb_s1, txb_s2;
  logic                   pol_err_reg;
  logic                   seen_last_reg;
  logic                   one_bad_cap_reg;
  logic                   rd_pend_reg;
  logic                   perr_reg;
  logic                   rabs_reg;
  logic                   gef_now;
  logic                   zero_clk;
  logic                   frame_err;
  logic                   cmd_ok;
  logic                   clr_gstat;

  // ----------------------------------------------------------------
  // link receive: falling edges, restarted by chip select high
  // ----------------------------------------------------------------
  assign rx_byte   = {SDI, rx_shift_reg[SFSR_BYTE_W-1:1]};  // bit 0 arrives first
  assign byte_done = (rx_cnt_reg[2:0] == 3'h7);
  assign rx_slot   = rx_cnt_reg[CNT_W-1:3];

  // frame bookkeeping; the async clear is the frame's own end, since the clock stops
  always_ff @(negedge SCLK or posedge CSN_B) begin
    if (CSN_B) begin
      rx_cnt_reg    <= '0;
      got_last_reg  <= 1'h0;
      one_bad_reg   <= 1'h0;
      resp_slot_reg <= '1;
    end else begin
      rx_cnt_reg <= CNT_W'(rx_cnt_reg + 1'h1);
      if (byte_done && !got_last_reg) begin
        if (!rx_byte[SFSR_AB_ONE_POS]) begin
          one_bad_reg <= 1'h1;
        end
        if (rx_byte[SFSR_AB_LAST_POS]) begin
          got_last_reg  <= 1'h1;
          resp_slot_reg <= SLOT_W'(rx_slot + 1'h1);
        end
      end
    end
  end

  // byte capture; data only, address read by the core once the last-address marker crosses, the rest once the frame has ended
  always_ff @(negedge SCLK) begin
    rx_shift_reg <= rx_byte;
    if (byte_done) begin
      fwd_byte_reg <= rx_byte;
    end
    if (byte_done && !got_last_reg && rx_byte[SFSR_AB_LAST_POS]) begin
      own_addr_reg <= rx_byte;
    end
    if (byte_done && got_last_reg && rx_slot == resp_slot_reg) begin
      data_reg <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // link transmit: rising edges
  // ----------------------------------------------------------------
  assign tx_slot = tx_cnt_reg[CNT_W-1:3];

  // status first, response in the slot after the last address byte,
  // otherwise the byte received one slot earlier passes on down the chain
  always_comb begin
    if (tx_slot == '0) begin
      tx_load = status_snap_reg;
    end else if (tx_slot == resp_slot_reg) begin
      tx_load = rsp_reg;
    end else begin
      tx_load = fwd_byte_reg;
    end
  end

  // status and response words are frozen in the core well before they are loaded
  always_ff @(posedge SCLK or posedge CSN_B) begin
    if (CSN_B) begin
      tx_cnt_reg   <= '0;
      tx_shift_reg <= '0;
      tx_bit_reg   <= 1'h0;
    end else begin
      tx_cnt_reg <= CNT_W'(tx_cnt_reg + 1'h1);
      if (tx_cnt_reg[2:0] == 3'h0) begin
        tx_bit_reg   <= tx_load[0];
        tx_shift_reg <= {1'h0, tx_load[SFSR_BYTE_W-1:1]};
      end else begin
        tx_bit_reg   <= tx_shift_reg[0];
        tx_shift_reg <= {1'h0, tx_shift_reg[SFSR_BYTE_W-1:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // synchronisers into CLOCK
  // ----------------------------------------------------------------
  // first stages feed only second stages; edge detectors use stage two
  always_ff @(posedge CLOCK) begin
    csn_s1  <= CSN_B;
    csn_s2  <= csn_s1;
    sclk_s1 <= SCLK;
    sclk_s2 <= sclk_s1;
    sdi_s1  <= SDI;
    sdi_s2  <= sdi_s1;
    last_s1 <= got_last_reg;
    last_s2 <= last_s1;
    txb_s1  <= tx_bit_reg;
    txb_s2  <= txb_s1;
    csn_d   <= csn_s2;
    sclk_d  <= sclk_s2;
    last_d  <= last_s2;
  end

  // ----------------------------------------------------------------
  // status byte and fault summary
  // ----------------------------------------------------------------
  always_comb begin
    status_now                    = '0;
    status_now[SFSR_ST_TWARN_POS] = THERMAL_WARNING_BIT;
    status_now[SFSR_ST_TSHUT_POS] = THERMAL_SHUTDOWN_BIT;
    status_now[SFSR_ST_RABS_POS]  = rabs_reg;
    status_now[SFSR_ST_SHIGH_POS] = SUPPLY_HIGH_BIT;
    status_now[SFSR_ST_SLOW_POS]  = SUPPLY_LOW_BIT;
    status_now[SFSR_ST_LOAD_POS]  = (|OPEN_LOAD_FAULT) | (|OVERCURRENT_FAULT);
    status_now[SFSR_ST_PERR_POS]  = perr_reg;
    gef_now = perr_reg | status_now[SFSR_ST_LOAD_POS] | SUPPLY_LOW_BIT | SUPPLY_HIGH_BIT
            | !rabs_reg | THERMAL_SHUTDOWN_BIT | THERMAL_WARNING_BIT;
  end

  // ----------------------------------------------------------------
  // end-of-frame evaluation
  // ----------------------------------------------------------------
  assign zero_clk  = (edge_cnt_reg == '0);
  assign frame_err = pol_err_reg
                   | (!zero_clk & (count_bad(edge_cnt_reg)
                                   | one_bad_cap_reg
                                   | !seen_last_reg
                                   | addr_unused(own_addr_reg)));
  assign cmd_ok    = (state_reg == SFSR_S_EVAL) && !frame_err && !zero_clk
                   && own_addr_reg[SFSR_AB_WR_POS];
  assign clr_gstat = cmd_ok
                   && own_addr_reg[SFSR_AB_ADDR_HI:SFSR_AB_ADDR_LO] == SFSR_GSTAT_ADDR;

  // frame tracker: counts clock edges, checks polarity, fetches the response
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      state_reg       <= SFSR_S_IDLE;
      edge_cnt_reg    <= '0;
      pol_err_reg     <= 1'h0;
      seen_last_reg   <= 1'h0;
      one_bad_cap_reg <= 1'h0;
      rd_pend_reg     <= 1'h0;
      RD_ADDR         <= '0;
      rsp_reg         <= '0;
    end else begin
      rd_pend_reg <= 1'h0;
      if (rd_pend_reg) begin
        rsp_reg <= RD_DATA;
      end
      unique case (state_reg)
        SFSR_S_IDLE: begin
          if (!csn_s2 && csn_d) begin
            state_reg     <= SFSR_S_FRAME;
            pol_err_reg   <= sclk_s2;
            seen_last_reg <= 1'h0;
            edge_cnt_reg  <= '0;
          end
        end
        SFSR_S_FRAME: begin
          if (sclk_s2 && !sclk_d && edge_cnt_reg != '1) begin
            edge_cnt_reg <= CNT_W'(edge_cnt_reg + 1'h1);
          end
          // address is stable once the marker level has crossed
          if (last_s2 && !last_d) begin
            seen_last_reg   <= 1'h1;
            one_bad_cap_reg <= one_bad_reg;
            RD_ADDR         <= own_addr_reg[SFSR_AB_ADDR_HI:SFSR_AB_ADDR_LO];
            rd_pend_reg     <= 1'h1;
          end
          if (csn_s2 && !csn_d) begin
            state_reg   <= SFSR_S_EVAL;
            pol_err_reg <= pol_err_reg | sclk_s2;
          end
        end
        SFSR_S_EVAL: begin
          state_reg    <= SFSR_S_IDLE;
          edge_cnt_reg <= '0;
        end
      endcase
    end
  end

  // sticky bits: an error in the same frame as a clear keeps the bit set
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      perr_reg <= SFSR_PERR_RST;
      rabs_reg <= SFSR_RABS_RST;
    end else begin
      if (state_reg == SFSR_S_EVAL && frame_err) begin
        perr_reg <= 1'h1;
      end else if (clr_gstat) begin
        perr_reg <= 1'h0;
      end
      if (clr_gstat) begin
        rabs_reg <= 1'h1;
      end
    end
  end

  // command strobe carries only clean frames
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      CMD_STB   <= 1'h0;
      CMD_WRITE <= 1'h0;
      CMD_ADDR  <= '0;
      CMD_DATA  <= '0;
    end else begin
      CMD_STB <= cmd_ok;
      if (cmd_ok) begin
        CMD_WRITE <= own_addr_reg[SFSR_AB_WR_POS];
        CMD_ADDR  <= own_addr_reg[SFSR_AB_ADDR_HI:SFSR_AB_ADDR_LO];
        CMD_DATA  <= data_reg;
      end
    end
  end

  // status snapshot frozen while selected; flags and serial output
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      status_snap_reg    <= SFSR_SNAP_RST;
      FAULT_SUMMARY_FLAG <= 1'h1;
      RESET_ABSENT_BIT   <= SFSR_RABS_RST;
      PROTO_ERR_BIT      <= SFSR_PERR_RST;
      SDO_O              <= 1'h0;
      SDO_OE             <= 1'h0;
    end else begin
      if (csn_s2 && state_reg == SFSR_S_IDLE) begin
        status_snap_reg <= status_now;
      end
      FAULT_SUMMARY_FLAG <= gef_now;
      RESET_ABSENT_BIT   <= rabs_reg;
      PROTO_ERR_BIT      <= perr_reg;
      SDO_OE             <= !csn_s2;
      if (csn_s2) begin
        SDO_O <= 1'h0;
      end else if (edge_cnt_reg == '0) begin
        SDO_O <= gef_now | sdi_s2;
      end else begin
        SDO_O <= txb_s2;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  sequence s_err_end;
    state_reg == SFSR_S_EVAL && frame_err;
  endsequence
  sequence s_back_idle;
    state_reg == SFSR_S_IDLE && csn_s2;
  endsequence

  property p_preclock;
    (!csn_s2 && edge_cnt_reg == '0 && gef_now) |=> SDO_O;
  endproperty
  a_preclock: assert property (p_preclock) else $error("summary missing before clock");

  property p_rabs_fault;
    !rabs_reg |=> FAULT_SUMMARY_FLAG;
  endproperty
  a_rabs_fault: assert property (p_rabs_fault) else $error("summary low after reset");

  property p_zero_ok;
    (state_reg == SFSR_S_EVAL && zero_clk && !pol_err_reg) |-> !frame_err;
  endproperty
  a_zero_ok: assert property (p_zero_ok) else $error("clockless frame flagged");

  property p_snap_err;
    s_err_end ##1 s_back_idle |=> status_snap_reg[SFSR_ST_PERR_POS];
  endproperty
  a_snap_err: assert property (p_snap_err) else $error("error not in next status");

  property p_load;
    (|OPEN_LOAD_FAULT || |OVERCURRENT_FAULT) |=> FAULT_SUMMARY_FLAG;
  endproperty
  a_load: assert property (p_load) else $error("load fault not summarised");

  property p_rabs_hold;
    (!rabs_reg && !clr_gstat) |=> !rabs_reg;
  endproperty
  a_rabs_hold: assert property (p_rabs_hold) else $error("reset-absent set uncommanded");

  property p_perr_next;
    s_err_end |=> perr_reg [*2];
  endproperty
  a_perr_next: assert property (p_perr_next) else $error("protocol error not kept");

  property p_short;
    (state_reg == SFSR_S_EVAL && edge_cnt_reg > 0 && edge_cnt_reg < 16) |-> frame_err;
  endproperty
  a_short: assert property (p_short) else $error("short frame accepted");

  property p_odd;
    (state_reg == SFSR_S_EVAL && edge_cnt_reg[2:0] != 3'h0) |-> frame_err;
  endproperty
  a_odd: assert property (p_odd) else $error("partial byte accepted");

  property p_pol;
    (state_reg == SFSR_S_IDLE && !csn_s2 && csn_d && sclk_s2) |=>
      pol_err_reg throughout (state_reg == SFSR_S_FRAME);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity error missed");

  property p_release;
    csn_s2 |=> !SDO_OE;
  endproperty
  a_release: assert property (p_release) else $error("output not released");

  property p_no_self_clear;
    $fell(perr_reg) |-> $past(clr_gstat);
  endproperty
  a_no_self_clear: assert property (p_no_self_clear) else $error("error bit self-cleared");

  property p_cmd_clean;
    CMD_STB |-> $past(state_reg == SFSR_S_EVAL && !frame_err) ##1 !CMD_STB;
  endproperty
  a_cmd_clean: assert property (p_cmd_clean) else $error("command from bad frame");

endmodule // sfsr_responder
`default_nettype wire

// [testbench/sfsr_host.sv]
// partner model: host master that drives the serial link of the responder
`timescale 1ns/1ps
`default_nettype none
module sfsr_host #(
  parameter realtime HALF = 62.5
) (
  output var  logic sclk,
  output var  logic csn_b,
  output var  logic sdi,
  input  wire logic sdo_o,
  input  wire logic sdo_oe
);
  logic miso;

  // released output line settles to the pull-up level
  assign miso = sdo_oe ? sdo_o : 1'h1;

  // idle: deselected, no clock outside frames
  initial begin
    sclk  = 1'h0;
    csn_b = 1'h1;
    sdi   = 1'h1;
  end

  // ----------------------------------------------------------------
  // one frame, lsb first; pol_err leaves the clock high at select
  // ----------------------------------------------------------------
  task automatic xfer(input int n, input logic [15:0] tx, input bit pol_err,
                      output logic fault_summary_flag, output logic [15:0] rx);
    rx    = 16'h0000;
    sclk  = pol_err;
    sdi   = 1'h0;
    #(HALF);
    csn_b = 1'h0;
    #(HALF);
    sclk  = 1'h0;
    #(HALF);
    fault_summary_flag   = miso;
    for (int i = 0; i < n; i++) begin
      sclk  = 1'h1;
      sdi   = tx[i];
      #(HALF);
      sclk  = 1'h0;
      rx[i] = miso;
      #(HALF);
    end
    csn_b = 1'h1;
    #(HALF);
    sdi   = ~sdi;  // no stale level once the frame is over
  endtask
endmodule // sfsr_host
`default_nettype wire

// [testbench/spi_frame_status_responder_tb.sv]
// testbench: self-checking run of the serial frame status responder
`timescale 1ns/1ps
`default_nettype none
module spi_frame_status_responder_tb
  import sfsr_pkg::*;
();
  logic        clock, rst_b, sclk, csn_b, sdi, sdo_o, sdo_oe, flag, rabs, perr;
  logic        cmd_stb, cmd_write, gf;
  logic [4:0]  rd_addr, cmd_addr;
  logic [7:0]  rd_data, cmd_data;
  logic [5:0]  fv;
  logic [15:0] rx;
  int          err_total, cmp_count, stb_total;
  int          pos [6] = '{SFSR_ST_TWARN_POS, SFSR_ST_TSHUT_POS, SFSR_ST_SHIGH_POS,
                           SFSR_ST_SLOW_POS, SFSR_ST_LOAD_POS, SFSR_ST_LOAD_POS};
  int          nt [6]  = '{12, 8, 16, 16, 16, 16};
  logic [7:0]  at [6]  = '{8'h8f, 8'h8f, 8'hff, 8'h8e, 8'h8d, 8'h8f};

  sfsr_responder uut (
    .CLOCK(clock), .RST_B(rst_b), .SCLK(sclk), .CSN_B(csn_b), .SDI(sdi),
    .SDO_O(sdo_o), .SDO_OE(sdo_oe),
    .OPEN_LOAD_FAULT({4'h0, fv[4], 3'h0}), .OVERCURRENT_FAULT({fv[5], 7'h00}),
    .SUPPLY_LOW_BIT(fv[3]), .SUPPLY_HIGH_BIT(fv[2]),
    .THERMAL_SHUTDOWN_BIT(fv[1]), .THERMAL_WARNING_BIT(fv[0]),
    .FAULT_SUMMARY_FLAG(flag), .RESET_ABSENT_BIT(rabs), .PROTO_ERR_BIT(perr),
    .RD_ADDR(rd_addr), .RD_DATA(rd_data), .CMD_STB(cmd_stb), .CMD_WRITE(cmd_write),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data)
  );

  sfsr_host host (
    .sclk(sclk), .csn_b(csn_b), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe)
  );

  // core clock and a register file whose contents follow the address
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  always @(negedge clock) rd_data <= {3'h5, rd_addr};
  // strobes counted away from the edge that launches them
  always @(negedge clock) if (cmd_stb === 1'h1) stb_total <= stb_total + 1;

  // ----------------------------------------------------------------
  // checking and frame tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // frame, then a bounded wait for the output to be released
  task automatic frame(input int n, input logic [15:0] tx, input bit pol);
    int k;
    host.xfer(n, tx, pol, gf, rx);
    k = 0;
    while (sdo_oe !== 1'h0 && k < 40) begin
      @(negedge clock);
      k++;
    end
    if (sdo_oe !== 1'h0) begin
      err_total++;
      $display("mismatch sdo_release expected 0 seen 1");
      report_and_stop();
    end
    repeat (8) @(negedge clock);
  endtask

  // read frame: flag on the line, status byte, in-frame response
  task automatic rd_check(input logic [4:0] a, input logic [7:0] st, input logic g);
    int s0;
    s0 = stb_total;
    frame(16, {8'h5b, 1'h0, a, 2'h3}, 1'b0);
    chk("line_flag", {15'h0, g}, {15'h0, gf});
    chk("status_byte", {8'h00, st}, {8'h00, rx[7:0]});
    chk("response", {8'h00, 3'h5, a}, {8'h00, rx[15:8]});
    chk("read_strobes", 16'h0, 16'(stb_total - s0));
  endtask

  // operation-1 frame; bad ones must be refused and flagged
  task automatic cmd(input int n, input logic [7:0] ab, input bit pol, input bit bad);
    int s0;
    s0 = stb_total;
    frame(n, {8'ha5, ab}, pol);
    chk("cmd_strobes", 16'(!bad), 16'(stb_total - s0));
    chk("proto_err", {15'h0, bad}, {15'h0, perr});
    if (!bad) chk("cmd_fields", {2'h0, 1'h1, ab[6:2], 8'ha5},
                  {2'h0, cmd_write, cmd_addr, cmd_data});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b     = 1'h0;
    fv        = 6'h00;
    err_total = 0;
    cmp_count = 0;
    stb_total = 0;
    repeat (10) @(negedge clock);
    rst_b = 1'h1;
    repeat (6) @(negedge clock);
    chk("reset_flags", 16'h4, {13'h0, flag, rabs, perr});
    frame(0, 16'h0000, 1'b0);
    chk("zero_clock_flag", 16'h1, {15'h0, gf});
    chk("zero_clock_err", 16'h0, {15'h0, perr});
    rd_check(5'h05, 8'h00, 1'h1);
    cmd(16, {1'h1, SFSR_GSTAT_ADDR, 2'h3}, 1'b0, 1'b0);
    chk("absent_and_flag", 16'h2, {14'h0, rabs, flag});
    rd_check(SFSR_GSTAT_ADDR, 8'h04, 1'h0);
    // each fault source alone raises the flag and its status bit
    for (int f = 0; f < 6; f++) begin
      fv = 6'h01 << f;
      repeat (4) @(negedge clock);
      chk("flag_on_fault", 16'h1, {15'h0, flag});
      rd_check(5'h09, 8'h04 | (8'h01 << pos[f]), 1'h1);
      fv = 6'h00;
      repeat (4) @(negedge clock);
      chk("flag_cleared", 16'h0, {15'h0, flag});
    end
    // each kind of malformed frame, reported in the next frame, then cleared
    for (int e = 0; e < 6; e++) begin
      cmd(nt[e], at[e], e == 5, 1'b1);
      rd_check(SFSR_GSTAT_ADDR, 8'h84, 1'h1);
      cmd(16, {1'h1, SFSR_GSTAT_ADDR, 2'h3}, 1'b0, 1'b0);
    end
    cmd(16, 8'h8f, 1'b0, 1'b0);
    report_and_stop();
  end

  // hang guard
  initial begin
    #400000;
    err_total++;
    $display("mismatch run_time expected finish seen hang");
    report_and_stop();
  end
endmodule // spi_frame_status_responder_tb
`default_nettype wire
